/* File: bfsm_defines.vh */
// Shared constants of the two-direction queue with mailboxes.
// Assumes inclusion by bare name from the queue and top design files of the block.
`ifndef BFSM_DEFINES_VH
`define BFSM_DEFINES_VH

// ----------------------------------------------------------------
// Widths and default depth
// ----------------------------------------------------------------
`define BFSM_DATA_W 36
`define BFSM_DEPTH_DEF 256
`define BFSM_BYTE_W 9
`define BFSM_WORD_W 18

// ----------------------------------------------------------------
// Default partial flag offsets, in long words
// ----------------------------------------------------------------
`define BFSM_AE_OFFSET_DEF 8
`define BFSM_AF_OFFSET_DEF 8

// ----------------------------------------------------------------
// Index of the last piece of a long word on the right port
// ----------------------------------------------------------------
`define BFSM_PIECES_LONG 2'd0
`define BFSM_PIECES_WORD 2'd1
`define BFSM_PIECES_BYTE 2'd3

// ----------------------------------------------------------------
// Select encodings (chip select active low)
// ----------------------------------------------------------------
`define BFSM_LEFT_DIR_WRITE 1'b1
`define BFSM_RIGHT_DIR_WRITE 1'b0
`define BFSM_MBX_QUEUE 1'b0
`define BFSM_MBX_MAIL 1'b1

`endif

/* File: bfsm_edge.v */
// Rising edge detector for a port clock sampled as a plain input.
// Assumes the port clock is synchronous to clk and slower than half its rate.
module bfsm_edge (
    input wire clk,
    input wire arst_n,
    input wire port_clock,
    output reg rise_reg
);

reg prev_reg;

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        prev_reg <= 1'b0;
        rise_reg <= 1'b0;
    end else begin
        prev_reg <= port_clock;
        rise_reg <= port_clock & ~prev_reg;
    end
end

endmodule

/* File: bfsm_queue.v */
// One direction of storage: flip-flop memory with write and read pointers.
// Assumes push only when not full and pop only when not empty.
`include "bfsm_defines.vh"
module bfsm_queue #(
    parameter WIDTH = `BFSM_DATA_W,
    parameter DEPTH = `BFSM_DEPTH_DEF,
    parameter AW = 8
) (
    input wire clk,
    input wire arst_n,
    input wire wr_tick,
    input wire rd_tick,
    input wire push,
    input wire pop,
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] head,
    output wire [AW:0] wr_level,
    output wire [AW:0] rd_level
);

reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
reg [AW:0] wr_ptr_reg;
reg [AW:0] rd_ptr_reg;
reg [AW:0] rd_meta_reg;
reg [AW:0] rd_seen_reg;
reg [AW:0] wr_meta_reg;
reg [AW:0] wr_seen_reg;

// ----------------------------------------------------------------
// Pointers; local moves count at once, far moves after two local edges
// ----------------------------------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        wr_ptr_reg <= {(AW+1){1'b0}};
        rd_ptr_reg <= {(AW+1){1'b0}};
        rd_meta_reg <= {(AW+1){1'b0}};
        rd_seen_reg <= {(AW+1){1'b0}};
        wr_meta_reg <= {(AW+1){1'b0}};
        wr_seen_reg <= {(AW+1){1'b0}};
    end else begin
        if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1; // [RL22]
        if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1; // [RL22]
        if (wr_tick) begin
            rd_meta_reg <= rd_ptr_reg; // [RL21]
            rd_seen_reg <= rd_meta_reg; // [RL21]
        end
        if (rd_tick) begin
            wr_meta_reg <= wr_ptr_reg; // [RL21]
            wr_seen_reg <= wr_meta_reg; // [RL21]
        end
    end
end

// Storage holds no reset; contents are undefined until written
always @(posedge clk) begin
    if (push)
        mem_reg[wr_ptr_reg[AW-1:0]] <= din;
end

assign head = mem_reg[rd_ptr_reg[AW-1:0]];
assign wr_level = wr_ptr_reg - rd_seen_reg;
assign rd_level = wr_seen_reg - rd_ptr_reg;

endmodule

/* File: bfsm_top.v */
// Two-direction queue with flag crossing, right port sizing and mailboxes.
// Assumes both port clocks are plain inputs sampled by clk, much slower than it.
// How it works
// RL1 - Left input-ready rises after right frees space
// RL2 - Left full clears after right frees space
// RL3 - Right input-ready rises after left frees space
// RL4 - Right full clears after left frees space
// RL5 - Right almost-empty clears after left fills
// RL6 - Left almost-empty clears after right fills
// RL7 - Left almost-full clears after right drains
// RL8 - Right almost-full clears after left drains
// RL9 - Narrow right port counts only final piece
// RL10 - Right full sets on final written piece
// RL11 - Right almost-empty sets on final read piece
// RL12 - Right almost-full sets on final written piece
// RL13 - Forward queue selects: cs low, dir high
// RL14 - Reverse queue selects: cs, dir, mbx low
// RL15 - Almost-full measured against parameter depth
// RL16 - Word width: forward mail carries lanes 0-17
// RL17 - Byte width: forward mail carries lanes 0-8
// RL18 - Word width: reverse mail carries lanes 0-17
// RL19 - Byte width: reverse mail carries lanes 0-8
// RL20 - Byte order latched once after reset release; sizing static
// RL21 - Far-side flags pass a two-stage crossing
// RL22 - Local flag changes take effect immediately
`include "bfsm_defines.vh"

module bfsm_top #(
    parameter DEPTH = `BFSM_DEPTH_DEF,
    parameter AE_OFFSET = `BFSM_AE_OFFSET_DEF,
    parameter AF_OFFSET = `BFSM_AF_OFFSET_DEF
) (
    input wire clk,
    input wire arst_n,
    input wire fall_through_mode,
    input wire bus_match_select,
    input wire right_byte_size,
    input wire byte_order_select,
    input wire left_port_clock,
    input wire left_chip_select_n,
    input wire left_direction,
    input wire left_mailbox_select,
    input wire left_transfer_enable,
    input wire [35:0] left_data_in,
    output reg [35:0] left_data_out,
    output reg left_data_oe,
    output reg left_input_ready,
    output reg left_full_n,
    output reg left_empty_n,
    output reg left_almost_empty_n,
    output reg left_almost_full_n,
    output reg reverse_mail_flag_n,
    input wire right_port_clock,
    input wire right_chip_select_n,
    input wire right_direction,
    input wire right_mailbox_select,
    input wire right_transfer_enable,
    input wire [35:0] right_data_in,
    output reg [35:0] right_data_out,
    output reg right_data_oe,
    output reg right_input_ready,
    output reg right_full_n,
    output reg right_empty_n,
    output reg right_almost_empty_n,
    output reg right_almost_full_n,
    output reg forward_mail_flag_n
);

localparam AW = $clog2(DEPTH);
// Levels worked out in 32 bits, then cut to the pointer width on purpose
localparam [31:0] DEPTH_W = DEPTH;
localparam [31:0] AF_W = DEPTH - AF_OFFSET;
localparam [31:0] AE_W = AE_OFFSET;
localparam [AW:0] FULL_LVL = DEPTH_W[AW:0]; // [RL15]
localparam [AW:0] AF_LVL = AF_W[AW:0]; // [RL15]
localparam [AW:0] AE_LVL = AE_W[AW:0];

wire left_tick;
wire right_tick;
wire [35:0] fwd_head;
wire [35:0] rev_head;
wire [AW:0] fwd_wr_level;
wire [AW:0] fwd_rd_level;
wire [AW:0] rev_wr_level;
wire [AW:0] rev_rd_level;

reg order_big_reg;
reg order_taken_reg;
reg [1:0] wpiece_reg;
reg [1:0] rpiece_reg;
reg [35:0] assemble_reg;
reg [35:0] assemble_next;
reg [35:0] forward_mailbox_reg;
reg [35:0] reverse_mailbox_reg;
reg [1:0] last_piece;
reg [1:0] lane_sel;
reg [35:0] right_lane;

// ----------------------------------------------------------------
// Port clock edges
// ----------------------------------------------------------------
bfsm_edge u_left_edge (
    .clk(clk),
    .arst_n(arst_n),
    .port_clock(left_port_clock),
    .rise_reg(left_tick)
);

bfsm_edge u_right_edge (
    .clk(clk),
    .arst_n(arst_n),
    .port_clock(right_port_clock),
    .rise_reg(right_tick)
);

// ----------------------------------------------------------------
// Access decode
// ----------------------------------------------------------------
wire left_sel = left_tick & ~left_chip_select_n & left_transfer_enable;
wire right_sel = right_tick & ~right_chip_select_n & right_transfer_enable;
wire left_wr = left_sel & (left_direction == `BFSM_LEFT_DIR_WRITE); // [RL13]
wire left_rd = left_sel & (left_direction != `BFSM_LEFT_DIR_WRITE); // [RL14]
wire right_wr = right_sel & (right_direction == `BFSM_RIGHT_DIR_WRITE); // [RL14]
wire right_rd = right_sel & (right_direction != `BFSM_RIGHT_DIR_WRITE); // [RL13]
wire left_q = left_mailbox_select == `BFSM_MBX_QUEUE;
wire right_q = right_mailbox_select == `BFSM_MBX_QUEUE;

wire fwd_full = fwd_wr_level == FULL_LVL;
wire fwd_empty = fwd_rd_level == {(AW+1){1'b0}};
wire rev_full = rev_wr_level == FULL_LVL;
wire rev_empty = rev_rd_level == {(AW+1){1'b0}};

// Only the final piece of a long word moves a pointer
wire right_last_w = wpiece_reg == last_piece;
wire right_last_r = rpiece_reg == last_piece;
wire fwd_push = left_wr & left_q & ~fwd_full;
wire fwd_pop = right_rd & right_q & ~fwd_empty & right_last_r; // [RL9] [RL11]
wire rev_push = right_wr & right_q & ~rev_full & right_last_w; // [RL9] [RL10] [RL12]
wire rev_pop = left_rd & left_q & ~rev_empty;

// ----------------------------------------------------------------
// Right port sizing
// ----------------------------------------------------------------
always @* begin
    if (!bus_match_select)
        last_piece = `BFSM_PIECES_LONG;
    else if (right_byte_size)
        last_piece = `BFSM_PIECES_BYTE;
    else
        last_piece = `BFSM_PIECES_WORD;
end

// Big order: first piece is the most significant lane
always @* begin
    lane_sel = order_big_reg ? (last_piece - rpiece_reg) : rpiece_reg;
    right_lane = 36'h0;
    if (!bus_match_select)
        right_lane = fwd_head;
    else if (right_byte_size)
        right_lane[8:0] = fwd_head[lane_sel*`BFSM_BYTE_W +: `BFSM_BYTE_W];
    else
        right_lane[17:0] = fwd_head[lane_sel[0]*`BFSM_WORD_W +: `BFSM_WORD_W];
end

always @* begin
    assemble_next = right_data_in;
    if (bus_match_select && right_byte_size) begin
        if (order_big_reg)
            assemble_next = {assemble_reg[26:0], right_data_in[8:0]};
        else
            assemble_next = {right_data_in[8:0], assemble_reg[35:9]};
    end else if (bus_match_select) begin
        if (order_big_reg)
            assemble_next = {assemble_reg[17:0], right_data_in[17:0]};
        else
            assemble_next = {right_data_in[17:0], assemble_reg[35:18]};
    end
end

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
bfsm_queue #(
    .WIDTH(`BFSM_DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
) u_forward_queue (
    .clk(clk),
    .arst_n(arst_n),
    .wr_tick(left_tick),
    .rd_tick(right_tick),
    .push(fwd_push),
    .pop(fwd_pop),
    .din(left_data_in),
    .head(fwd_head),
    .wr_level(fwd_wr_level),
    .rd_level(fwd_rd_level)
);

bfsm_queue #(
    .WIDTH(`BFSM_DATA_W),
    .DEPTH(DEPTH),
    .AW(AW)
) u_reverse_queue (
    .clk(clk),
    .arst_n(arst_n),
    .wr_tick(right_tick),
    .rd_tick(left_tick),
    .push(rev_push),
    .pop(rev_pop),
    .din(assemble_next),
    .head(rev_head),
    .wr_level(rev_wr_level),
    .rd_level(rev_rd_level)
);

// ----------------------------------------------------------------
// Byte order capture, piece counters, mailboxes
// ----------------------------------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        order_big_reg <= 1'b0;
        order_taken_reg <= 1'b0;
        wpiece_reg <= 2'h0;
        rpiece_reg <= 2'h0;
        assemble_reg <= 36'h0;
        forward_mailbox_reg <= 36'h0;
        reverse_mailbox_reg <= 36'h0;
        forward_mail_flag_n <= 1'b1;
        reverse_mail_flag_n <= 1'b1;
    end else begin
        // Caught once after reset release; later changes are ignored
        if (!order_taken_reg) begin
            order_big_reg <= byte_order_select; // [RL20]
            order_taken_reg <= 1'b1;
        end
        if (right_wr && right_q && !rev_full) begin
            assemble_reg <= assemble_next;
            wpiece_reg <= right_last_w ? 2'h0 : wpiece_reg + 2'h1;
        end
        if (right_rd && right_q && !fwd_empty)
            rpiece_reg <= right_last_r ? 2'h0 : rpiece_reg + 2'h1;
        // Narrow right port: upper lanes held at zero
        if (left_wr && !left_q) begin
            forward_mailbox_reg <= 36'h0;
            if (!bus_match_select)
                forward_mailbox_reg <= left_data_in;
            else if (right_byte_size)
                forward_mailbox_reg[8:0] <= left_data_in[8:0]; // [RL17]
            else
                forward_mailbox_reg[17:0] <= left_data_in[17:0]; // [RL16]
            forward_mail_flag_n <= 1'b0;
        end else if (right_rd && !right_q) begin
            forward_mail_flag_n <= 1'b1;
        end
        if (right_wr && !right_q) begin
            reverse_mailbox_reg <= 36'h0;
            if (!bus_match_select)
                reverse_mailbox_reg <= right_data_in;
            else if (right_byte_size)
                reverse_mailbox_reg[8:0] <= right_data_in[8:0]; // [RL19]
            else
                reverse_mailbox_reg[17:0] <= right_data_in[17:0]; // [RL18]
            reverse_mail_flag_n <= 1'b0;
        end else if (left_rd && !left_q) begin
            reverse_mail_flag_n <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Flags and data outputs, refreshed every clk
// ----------------------------------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        left_input_ready <= 1'b0;
        left_full_n <= 1'b0;
        left_empty_n <= 1'b0;
        left_almost_empty_n <= 1'b0;
        left_almost_full_n <= 1'b1;
        right_input_ready <= 1'b0;
        right_full_n <= 1'b0;
        right_empty_n <= 1'b0;
        right_almost_empty_n <= 1'b0;
        right_almost_full_n <= 1'b1;
        left_data_out <= 36'h0;
        left_data_oe <= 1'b0;
        right_data_out <= 36'h0;
        right_data_oe <= 1'b0;
    end else begin
        left_input_ready <= fall_through_mode & ~fwd_full; // [RL1]
        left_full_n <= fall_through_mode | ~fwd_full; // [RL2]
        right_input_ready <= fall_through_mode & ~rev_full; // [RL3] [RL10]
        right_full_n <= fall_through_mode | ~rev_full; // [RL4] [RL10]
        right_almost_empty_n <= fwd_rd_level > AE_LVL; // [RL5] [RL11]
        left_almost_empty_n <= rev_rd_level > AE_LVL; // [RL6]
        left_almost_full_n <= fwd_wr_level < AF_LVL; // [RL7]
        right_almost_full_n <= rev_wr_level < AF_LVL; // [RL8] [RL12]
        left_empty_n <= ~rev_empty;
        right_empty_n <= ~fwd_empty;
        left_data_out <= left_q ? rev_head : reverse_mailbox_reg;
        left_data_oe <= ~left_chip_select_n & (left_direction != `BFSM_LEFT_DIR_WRITE);
        right_data_out <= right_q ? right_lane : forward_mailbox_reg;
        right_data_oe <= ~right_chip_select_n & (right_direction != `BFSM_RIGHT_DIR_WRITE);
    end
end

endmodule

/* File: bfsm_port.sv */
// Partner master for one port: free-running port clock, one access per call.
// Assumes clk is the queue's system clock; HALF is the port half period in clk cycles.
module bfsm_port #(
    parameter int HALF = 4
) (
    input wire logic clk,
    output logic pclk,
    output logic cs_n,
    output logic dir,
    output logic mbx,
    output logic en,
    output logic [35:0] wd,
    input wire logic [35:0] rd
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        pclk = 1'b0;
        cs_n = 1'b1;
        dir = 1'b0;
        mbx = 1'b0;
        en = 1'b0;
        wd = 36'h0;
    end
    // Runs free, as the ports allow; every phase lasts HALF clk cycles
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) pclk <= !pclk;
    end
    task automatic edge_at(input logic lvl);
        @(posedge clk);
        while (!(pclk == lvl && cnt == HALF - 1)) @(posedge clk);
    endtask
    // Lines change only where the port clock falls, so they stand over the rise
    task automatic xfer(input logic d, input logic m, input logic [35:0] w, output logic [35:0] r);
        edge_at(1'b1);
        cs_n <= 1'b0;
        en <= 1'b1;
        dir <= d;
        mbx <= m;
        wd <= w;
        edge_at(1'b0);
        @(negedge clk);
        @(negedge clk);
        r = rd;
        edge_at(1'b1);
        cs_n <= 1'b1;
        en <= 1'b0;
        // Released data shows the inverse, never the last value
        wd <= ~wd;
        @(negedge clk);
    endtask
endmodule

/* File: bfsm_top_chk.sv */
// Flag timing checker on the ports of the queue top.
// Assumes bind to bfsm_top; port clocks are sampled by clk as the design does.
module bfsm_top_chk (
    input wire clk,
    input wire arst_n,
    input wire fall_through_mode,
    input wire left_port_clock,
    input wire left_chip_select_n,
    input wire left_direction,
    input wire left_mailbox_select,
    input wire left_transfer_enable,
    input wire left_input_ready,
    input wire left_full_n,
    input wire left_almost_full_n,
    input wire left_almost_empty_n,
    input wire right_port_clock,
    input wire right_chip_select_n,
    input wire right_direction,
    input wire right_mailbox_select,
    input wire right_transfer_enable,
    input wire right_input_ready,
    input wire right_full_n,
    input wire right_almost_full_n,
    input wire right_almost_empty_n,
    input wire forward_mail_flag_n,
    input wire left_data_oe,
    input wire right_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Two rises of the flag's own port clock; a port slower than nine clk a phase needs more
    localparam int LAT = 40;
    logic lp_reg, rp_reg;
    logic [1:0] up_reg;
    logic [5:0] lw_reg, lr_reg, rw_reg, rr_reg;
    wire la = left_port_clock && !lp_reg && !left_chip_select_n && left_transfer_enable;
    wire ra = right_port_clock && !rp_reg && !right_chip_select_n && right_transfer_enable;
    wire lq = la && !left_mailbox_select;
    wire rq = ra && !right_mailbox_select;
    wire ls = fall_through_mode ? left_input_ready : left_full_n;
    wire rs = fall_through_mode ? right_input_ready : right_full_n;
    wire on = up_reg == 2'h3;
    function automatic logic [5:0] age(input logic hit, input logic [5:0] a);
        return hit ? 6'h00 : a + {5'h00, a != 6'h3f};
    endfunction
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {lp_reg, rp_reg, up_reg} <= 4'h0;
            {lw_reg, lr_reg, rw_reg, rr_reg} <= {4{6'h3f}};
        end else begin
            lp_reg <= left_port_clock;
            rp_reg <= right_port_clock;
            up_reg <= up_reg + {1'b0, up_reg != 2'h3};
            lw_reg <= age(lq && left_direction, lw_reg);
            lr_reg <= age(lq && !left_direction, lr_reg);
            rw_reg <= age(rq && !right_direction, rw_reg);
            rr_reg <= age(rq && right_direction, rr_reg);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    ff_full_off_a: assert property (on && fall_through_mode |-> left_full_n && right_full_n)
        else $error("full flag active in fall-through mode");
    std_ready_off_a: assert property (on && !fall_through_mode |-> !(left_input_ready || right_input_ready))
        else $error("input ready active in standard mode");
    left_space_a: assert property (on && $rose(ls) |-> rr_reg <= LAT)
        else $error("left space flag released without right read");
    right_space_a: assert property (on && $rose(rs) |-> lr_reg <= LAT)
        else $error("right space flag released without left read");
    right_ae_clr_a: assert property (on && $rose(right_almost_empty_n) |-> lw_reg <= LAT)
        else $error("right almost-empty cleared without left write");
    left_ae_clr_a: assert property (on && $rose(left_almost_empty_n) |-> rw_reg <= LAT)
        else $error("left almost-empty cleared without right write");
    left_af_clr_a: assert property (on && $rose(left_almost_full_n) |-> rr_reg <= LAT)
        else $error("left almost-full cleared without right read");
    right_af_clr_a: assert property (on && $rose(right_almost_full_n) |-> lr_reg <= LAT)
        else $error("right almost-full cleared without left read");
    left_full_set_a: assert property ($fell(ls) |-> lw_reg <= 4)
        else $error("left space flag set late");
    right_full_set_a: assert property ($fell(rs) |-> rw_reg <= 4)
        else $error("right space flag set without right write");
    right_ae_set_a: assert property ($fell(right_almost_empty_n) |-> rr_reg <= 4)
        else $error("right almost-empty set without right read");
    right_af_set_a: assert property ($fell(right_almost_full_n) |-> rw_reg <= 4)
        else $error("right almost-full set without right write");
    mail_set_a: assert property (la && left_direction && left_mailbox_select |-> ##[1:4] !forward_mail_flag_n)
        else $error("forward mail flag not set after mailbox write");
    data_oe_a: assert property (on |-> left_data_oe == $past(!left_chip_select_n && !left_direction)
        && right_data_oe == $past(!right_chip_select_n && right_direction))
        else $error("data output enable does not follow read select");
    cover property (on && $rose(ls));
    cover property ($fell(right_almost_full_n));
    cover property ($rose(forward_mail_flag_n));
endmodule

bind bfsm_top bfsm_top_chk bfsm_top_chk_i (.*);

/* File: bfsm_top_test.sv */
// Self-checking bench: two partner ports around the queue, one row per setup.
// Assumes design files and checker are compiled first; depth 16, offsets 2.
module bfsm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic thru;
        logic narrow;
        logic bytew;
        logic big;
        logic [35:0] mask;
    } bfsm_row_t;
    // Setup inputs beside the lanes that should pass a mailbox
    localparam bfsm_row_t ROWS [4] = '{'{1'b0, 1'b0, 1'b0, 1'b0, 36'hfffffffff},
        '{1'b1, 1'b1, 1'b0, 1'b1, 36'h00003ffff}, '{1'b0, 1'b1, 1'b1, 1'b0, 36'h0000001ff},
        '{1'b1, 1'b1, 1'b1, 1'b1, 36'h0000001ff}};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic fall_through_mode = 1'b0;
    logic bus_match_select = 1'b0;
    logic right_byte_size = 1'b0;
    logic byte_order_select = 1'b0;
    wire left_port_clock, left_chip_select_n, left_direction, left_mailbox_select;
    wire right_port_clock, right_chip_select_n, right_direction, right_mailbox_select;
    wire left_transfer_enable, right_transfer_enable, left_data_oe, right_data_oe;
    wire [35:0] left_data_in, left_data_out, right_data_in, right_data_out;
    wire left_input_ready, left_full_n, left_empty_n, left_almost_empty_n, left_almost_full_n;
    wire right_input_ready, right_full_n, right_empty_n, right_almost_empty_n;
    wire right_almost_full_n, forward_mail_flag_n, reverse_mail_flag_n;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int n = 1;
    bfsm_row_t row;
    logic [35:0] d;
    always #10 clk = ~clk;
    bfsm_top #(.DEPTH(16), .AE_OFFSET(2), .AF_OFFSET(2)) bfsm_top_i (.*);
    bfsm_port #(.HALF(4)) left_bfsm_port_i (.clk(clk), .pclk(left_port_clock),
        .cs_n(left_chip_select_n), .dir(left_direction), .mbx(left_mailbox_select),
        .en(left_transfer_enable), .wd(left_data_in), .rd(left_data_out));
    bfsm_port #(.HALF(5)) right_bfsm_port_i (.clk(clk), .pclk(right_port_clock),
        .cs_n(right_chip_select_n), .dir(right_direction), .mbx(right_mailbox_select),
        .en(right_transfer_enable), .wd(right_data_in), .rd(right_data_out));
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    // Four rows need some 11000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            err_count++;
            conclude();
        end
    end
    function automatic logic [35:0] lw(input int i);
        return 36'h5a5a5a5a0 + i * 36'h102040801;
    endfunction
    // Big order takes the first piece from the top lane
    function automatic logic [35:0] pc(input logic [35:0] v, input int p);
        int w;
        w = 36 / n;
        return (row.big ? v >> (36 - w * (p + 1)) : v >> (w * p)) & row.mask;
    endfunction
    function automatic logic lsp();
        return row.thru ? left_input_ready : left_full_n;
    endfunction
    function automatic logic rsp();
        return row.thru ? right_input_ready : right_full_n;
    endfunction
    initial begin
        for (int r = 0; r < 4; r++) begin
            row = ROWS[r];
            n = row.narrow ? (row.bytew ? 4 : 2) : 1;
            @(posedge clk);
            arst_n <= 1'b0;
            fall_through_mode <= row.thru;
            bus_match_select <= row.narrow;
            right_byte_size <= row.bytew;
            byte_order_select <= row.big;
            repeat (2) @(posedge clk);
            check(left_empty_n, 1'b0);
            check(right_almost_full_n, 1'b1);
            arst_n <= 1'b1;
            repeat (3) @(negedge clk);
            check({lsp(), rsp()}, 2'b11);
            left_bfsm_port_i.xfer(1'b1, 1'b1, 36'hfedcba987, d);
            check(forward_mail_flag_n, 1'b0);
            right_bfsm_port_i.xfer(1'b1, 1'b1, 36'h0, d);
            check(d, 36'hfedcba987 & row.mask);
            check(forward_mail_flag_n, 1'b1);
            right_bfsm_port_i.xfer(1'b0, 1'b1, 36'h123456789, d);
            check(reverse_mail_flag_n, 1'b0);
            left_bfsm_port_i.xfer(1'b0, 1'b1, 36'h0, d);
            check(d, 36'h123456789 & row.mask);
            check(reverse_mail_flag_n, 1'b1);
            for (int i = 0; i < 17; i++) begin
                left_bfsm_port_i.xfer(1'b1, 1'b0, lw(i), d);
                if (i == 12 || i == 13) check(left_almost_full_n, i == 12);
            end
            check(lsp(), 1'b0);
            repeat (40) @(posedge clk);
            check(right_almost_empty_n, 1'b1);
            check(right_empty_n, 1'b1);
            for (int i = 0; i < 16; i++) begin
                for (int p = 0; p < n; p++) begin
                    right_bfsm_port_i.xfer(1'b1, 1'b0, 36'h0, d);
                    check(d, pc(lw(i), p));
                    if (i == 13 && p == n - 2) check(right_almost_empty_n, 1'b1);
                    if (i == 0 && p == n - 2) begin
                        repeat (40) @(posedge clk);
                        check(lsp(), 1'b0);
                    end
                end
                if (i == 0) begin
                    repeat (40) @(posedge clk);
                    check(lsp(), 1'b1);
                end
                check(right_almost_empty_n, i < 13);
            end
            repeat (40) @(posedge clk);
            check(left_almost_full_n, 1'b1);
            check(right_empty_n, 1'b0);
            for (int i = 0; i < 16; i++) begin
                for (int p = 0; p < n; p++) begin
                    right_bfsm_port_i.xfer(1'b0, 1'b0, pc(lw(i), p) | ~row.mask, d);
                    if (i == 15 && p == n - 2) check(rsp(), 1'b1);
                    if (i == 13 && p == n - 2) check(right_almost_full_n, 1'b1);
                end
                check(right_almost_full_n, i < 13);
            end
            check(rsp(), 1'b0);
            repeat (40) @(posedge clk);
            check(left_almost_empty_n, 1'b1);
            check(left_empty_n, 1'b1);
            for (int i = 0; i < 16; i++) begin
                left_bfsm_port_i.xfer(1'b0, 1'b0, 36'h0, d);
                check(d, lw(i));
                if (i == 0) begin
                    repeat (40) @(posedge clk);
                    check(rsp(), 1'b1);
                end
            end
            repeat (40) @(posedge clk);
            check(right_almost_full_n, 1'b1);
            check(left_empty_n, 1'b0);
        end
        conclude();
    end
endmodule
